//--- verilog/cdtdr_regs.sv
// Cable diagnostic and reflectometry register bank with live-link check control
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "cdtdr_map.svh"

module cdtdr_regs (
  input  wire logic                sys_clk,               // 10 MHz clock
  input  wire logic                resetn,                // Async reset, active low
  input  wire cdtdr_pkg::cdtdr_word_t reg_addr,           // Register address
  input  wire cdtdr_pkg::cdtdr_word_t reg_wdata,          // Write data
  input  wire logic                reg_wr,                // Write strobe
  input  wire logic                reg_rd,                // Read strobe
  output cdtdr_pkg::cdtdr_word_t   reg_rdata,             // Read data, cycle after strobe
  input  wire logic                live_check_done,       // Engine: live check finished
  input  wire logic [7:0]          live_check_sum_in,     // Engine: sum with done
  input  wire logic                tdr_result_valid,      // Engine: new peaks present
  input  wire logic [31:0]         transmit_pair_peaks,   // Engine: peaks 4..1, 8 bits each
  output logic                     gain_retrain_disable,  // Suppress gain retraining
  output logic                     live_check_launch,     // One-cycle launch pulse
  output logic                     cross_mode_disable,    // No cross-pair listening
  output logic                     transmit_pair_bypass,  // Skip transmit pair
  output logic                     rx_pair_bypass,        // Skip receive pair
  output logic [2:0]               avg_cycles_code,       // Averaging code
  output logic [3:0]               pulse_control,         // Expected self-reflection
  output logic [7:0]               listen_duration,       // Long-cable listening time
  output logic [4:0]               short_cable_threshold, // Short-cable threshold
  output logic                     irq                    // Level interrupt
);
  import cdtdr_pkg::*;

  cdtdr_state_t st;
  cdtdr_state_t next_st;

  function automatic logic hit(input cdtdr_word_t a, input cdtdr_word_t off);
    hit = (a == off);
  endfunction

  always_comb begin
    logic [1:0]  ev_set;
    logic [1:0]  ev_clr;
    cdtdr_word_t rd_mux;
    ev_set = 2'h0;
    ev_clr = 2'h0;
    rd_mux = 16'h0000;
    next_st        = st;
    next_st.launch = 1'b0;
    next_st.rdata  = 16'h0000;

    if (reg_wr && hit(reg_addr, `CDT_OFF_DSP5)) begin
      next_st.dsp5 = reg_wdata;
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_LIVE)) begin
      next_st.live_rsv = reg_wdata[3:0];
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_DIAG)) begin
      next_st.diag = reg_wdata & `CDT_DIAG_WMASK;
      if (reg_wdata[`CDT_AVG_HI:`CDT_AVG_LO] == `CDT_AVG_RSVD) begin
        next_st.diag[`CDT_AVG_HI:`CDT_AVG_LO] = st.diag[`CDT_AVG_HI:`CDT_AVG_LO];
      end
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_DIAG2)) begin
      next_st.diag2 = reg_wdata;
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_DIAG3)) begin
      next_st.diag3 = reg_wdata;
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_DIAG4)) begin
      next_st.diag4 = reg_wdata;
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_EV_ENABLE)) begin
      next_st.ev_enable = reg_wdata[1:0];
    end

    if (reg_wr && hit(reg_addr, `CDT_OFF_EV_CLEAR)) begin
      ev_clr = reg_wdata[1:0];
    end

    case (st.fsm)
      CDTDR_IDLE: begin
        if (reg_wr && hit(reg_addr, `CDT_OFF_LIVE) && reg_wdata[`CDT_LIVE_LAUNCH_BIT]) begin
          next_st.launch = 1'b1;
          next_st.fsm    = CDTDR_RUN;
        end
      end
      CDTDR_RUN: begin
        if (live_check_done) begin
          next_st.live_sum = live_check_sum_in;
          next_st.fsm      = CDTDR_IDLE;
          ev_set[`CDT_EV_LIVE_DONE] = 1'b1;
        end
      end
      default: begin
        next_st.fsm = CDTDR_IDLE;
      end
    endcase

    if (tdr_result_valid) begin
      next_st.peaks = transmit_pair_peaks;
      ev_set[`CDT_EV_PEAKS] = 1'b1;
    end

    // Set beats clear so no event is lost
    next_st.ev_status = (st.ev_status & ~ev_clr) | ev_set;
    next_st.irq       = |(next_st.ev_status & next_st.ev_enable);

    case (reg_addr)
      `CDT_OFF_DSP5:      rd_mux = st.dsp5;
      `CDT_OFF_LIVE:      rd_mux = {3'h0, (st.fsm == CDTDR_RUN), st.live_sum, st.live_rsv};
      `CDT_OFF_DIAG:      rd_mux = st.diag;
      `CDT_OFF_DIAG2:     rd_mux = st.diag2;
      `CDT_OFF_DIAG3:     rd_mux = st.diag3;
      `CDT_OFF_DIAG4:     rd_mux = st.diag4;
      `CDT_OFF_PEAK1:     rd_mux = st.peaks[15:0];
      `CDT_OFF_PEAK2:     rd_mux = st.peaks[31:16];
      `CDT_OFF_EV_STATUS: rd_mux = {14'h0000, st.ev_status};
      `CDT_OFF_EV_ENABLE: rd_mux = {14'h0000, st.ev_enable};
      default:            rd_mux = 16'h0000;
    endcase
    if (reg_rd) begin
      next_st.rdata = rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st           <= '0;
      st.fsm       <= CDTDR_IDLE;
      st.dsp5      <= `CDT_RST_DSP5;
      st.live_rsv  <= `CDT_RST_LIVE_RSV;
      st.diag      <= `CDT_RST_DIAG;
      st.diag2     <= `CDT_RST_DIAG2;
      st.diag3     <= `CDT_RST_DIAG3;
      st.diag4     <= `CDT_RST_DIAG4;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register
  assign reg_rdata             = st.rdata;
  assign gain_retrain_disable  = st.dsp5[`CDT_GAIN_DIS_BIT];
  assign live_check_launch     = st.launch;
  assign cross_mode_disable    = st.diag[`CDT_CROSS_DIS_BIT];
  assign transmit_pair_bypass  = st.diag[`CDT_TX_BYP_BIT];
  assign rx_pair_bypass        = st.diag[`CDT_RX_BYP_BIT];
  assign avg_cycles_code       = st.diag[`CDT_AVG_HI:`CDT_AVG_LO];
  assign pulse_control         = st.diag2[`CDT_PULSE_HI:`CDT_PULSE_LO];
  assign listen_duration       = st.diag3[`CDT_LISTEN_HI:`CDT_LISTEN_LO];
  assign short_cable_threshold = st.diag4[`CDT_SHORT_HI:`CDT_SHORT_LO];
  assign irq                   = st.irq;

  a_gain_follow:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DSP5 |=> gain_retrain_disable == $past(reg_wdata[11]))
  else $error("gain retrain disable not taken from write");

  a_launch_pulse:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_LIVE && reg_wdata[15] && st.fsm == CDTDR_IDLE
    |=> live_check_launch ##1 !live_check_launch)
  else $error("launch pulse missing or too long");

  a_launch_none:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    !(reg_wr && reg_addr == `CDT_OFF_LIVE && reg_wdata[15]) |=> !live_check_launch)
  else $error("launch without a launching write");

  a_running_read:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == `CDT_OFF_LIVE |=> reg_rdata[12] == ($past(st.fsm) == CDTDR_RUN))
  else $error("running flag wrong on read");

  a_running_end:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    st.fsm == CDTDR_RUN && live_check_done |=> st.fsm == CDTDR_IDLE && st.ev_status[0])
  else $error("check did not finish on done");

  a_cross_mode:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG |=> cross_mode_disable == $past(reg_wdata[14]))
  else $error("cross mode not taken from write");

  a_tx_bypass:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG |=> transmit_pair_bypass == $past(reg_wdata[13]))
  else $error("transmit bypass not taken from write");

  a_rx_bypass:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG |=> rx_pair_bypass == $past(reg_wdata[12]))
  else $error("receive bypass not taken from write");

  a_avg_reserved:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG && reg_wdata[10:8] == 3'h7 |=> $stable(avg_cycles_code))
  else $error("reserved averaging code stored");

  a_pulse_ctrl:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG2 |=> pulse_control == $past(reg_wdata[3:0]))
  else $error("pulse control not taken from write");

  a_listen_time:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG3 |=> listen_duration == $past(reg_wdata[15:8]))
  else $error("listen duration not taken from write");

  a_short_thresh:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_DIAG4 |=> short_cable_threshold == $past(reg_wdata[12:8]))
  else $error("short threshold not taken from write");

  a_peak_read:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    tdr_result_valid ##1 (!tdr_result_valid && reg_rd && reg_addr == `CDT_OFF_PEAK1)
    |=> reg_rdata == $past(transmit_pair_peaks[15:0], 2))
  else $error("first peak register wrong");

  a_sum_capture:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    st.fsm == CDTDR_RUN && live_check_done |=> st.live_sum == $past(live_check_sum_in))
  else $error("sum not captured");

  a_ro_ignore:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_PEAK1 && !tdr_result_valid |=> $stable(st.peaks))
  else $error("write changed read-only peaks");

  a_irq_raise:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    tdr_result_valid && st.ev_enable[1] && !(reg_wr && reg_addr == `CDT_OFF_EV_ENABLE) |=> irq)
  else $error("enabled event did not raise interrupt");

  a_gain_hold:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    !(reg_wr && reg_addr == `CDT_OFF_DSP5) |=> $stable(gain_retrain_disable))
  else $error("gain retrain disable moved without a write");

  a_running_start:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    st.fsm == CDTDR_IDLE && reg_wr && reg_addr == `CDT_OFF_LIVE && reg_wdata[15] |=> st.fsm == CDTDR_RUN)
  else $error("launch did not start the check");

  a_running_hold:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    st.fsm == CDTDR_RUN && !live_check_done |=> st.fsm == CDTDR_RUN)
  else $error("check ended without done");

  a_live_top_zero:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == `CDT_OFF_LIVE |=> reg_rdata[15:13] == 3'h0)
  else $error("launch or reserved bits read as one");

  a_diag_top_zero:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == `CDT_OFF_DIAG |=> !reg_rdata[15])
  else $error("read-only control bit read as one");

  a_idle_sum_hold:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    st.fsm == CDTDR_IDLE |=> $stable(st.live_sum))
  else $error("sum changed while idle");

  a_peak_capture:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    tdr_result_valid |=> st.peaks == $past(transmit_pair_peaks))
  else $error("peaks not captured");

  a_peak_hold:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    !tdr_result_valid |=> $stable(st.peaks))
  else $error("peaks changed without capture");

  // Read data only in the cycle after a read
  a_rdata_idle:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 16'h0000)
  else $error("read data without a read");

  // Set beats a clear in the same cycle
  a_set_wins:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    tdr_result_valid |=> st.ev_status[1])
  else $error("peak event lost");

  // Clear of both events drops the interrupt
  a_irq_clear:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_EV_CLEAR && reg_wdata[1:0] == 2'h3 && !tdr_result_valid && !live_check_done
    |=> !irq)
  else $error("interrupt stayed after clear");

  a_avg_legal:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    avg_cycles_code != `CDT_AVG_RSVD)
  else $error("reserved averaging code present");

  a_live_rsv_store:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == `CDT_OFF_LIVE |=> st.live_rsv == $past(reg_wdata[3:0]))
  else $error("reserved low bits not stored");

endmodule

//--- verilog/cdtdr_map.svh
// Register offsets, field positions and reset values of the cable diagnostic register bank
// Behaviour
// - Bit 11 of DSP config five set suppresses gain retraining; reset clears it.
// - Writing one to live-link bit 15 launches the check; bit self-clears, reads zero.
// - Live-link bit 12 reads one while the check runs, zero when finished.
// - Diagnostic control bit 14 at one disables cross-pair listening; zero enables it.
// - Diagnostic control bit 13 at one skips reflectometry on the transmit pair.
// - Diagnostic control bit 12 at one skips reflectometry on the receive pair.
// - Bits 10:8 choose averaged cycle count 1 to 32; 111 reserved; reset 110.
// - Bits 3:0 of control two set expected self-reflection; reset 1100.
// - Bits 15:8 of control three set long-cable listening time; reset all ones.
// - Bits 12:8 of control four hold short-cable threshold; reset 1 1000.
// - First four transmit-pair peaks read two per register, low peak low byte.
`ifndef CDTDR_MAP_SVH
`define CDTDR_MAP_SVH

`define CDT_OFF_DSP5        16'h0130
`define CDT_OFF_LIVE        16'h0155
`define CDT_OFF_DIAG        16'h0170
`define CDT_OFF_DIAG2       16'h0171
`define CDT_OFF_DIAG3       16'h0173
`define CDT_OFF_DIAG4       16'h0177
`define CDT_OFF_PEAK1       16'h0180
`define CDT_OFF_PEAK2       16'h0181
`define CDT_OFF_EV_STATUS   16'h0190
`define CDT_OFF_EV_ENABLE   16'h0191
`define CDT_OFF_EV_CLEAR    16'h0192

`define CDT_RST_DSP5        16'h0001
`define CDT_RST_LIVE_RSV    4'h1
`define CDT_RST_DIAG        16'h0e52
`define CDT_RST_DIAG2       16'hc85c
`define CDT_RST_DIAG3       16'hff1e
`define CDT_RST_DIAG4       16'h189b
`define CDT_DIAG_WMASK      16'h7fff

`define CDT_GAIN_DIS_BIT    11
`define CDT_LIVE_LAUNCH_BIT 15
`define CDT_LIVE_RUN_BIT    12
`define CDT_CROSS_DIS_BIT   14
`define CDT_TX_BYP_BIT      13
`define CDT_RX_BYP_BIT      12
`define CDT_AVG_HI          10
`define CDT_AVG_LO          8
`define CDT_AVG_RSVD        3'h7
`define CDT_PULSE_HI        3
`define CDT_PULSE_LO        0
`define CDT_LISTEN_HI       15
`define CDT_LISTEN_LO       8
`define CDT_SHORT_HI        12
`define CDT_SHORT_LO        8

`define CDT_EV_LIVE_DONE    0
`define CDT_EV_PEAKS        1

`endif

//--- verilog/cdtdr_pkg.sv
// Types shared by the cable diagnostic register bank
package cdtdr_pkg;

  typedef logic [15:0] cdtdr_word_t;

  typedef enum logic [1:0] {
    CDTDR_IDLE = 2'b01,
    CDTDR_RUN  = 2'b10
  } cdtdr_fsm_t;

  typedef struct packed {
    cdtdr_fsm_t  fsm;
    logic        launch;
    cdtdr_word_t dsp5;
    logic [3:0]  live_rsv;
    logic [7:0]  live_sum;
    cdtdr_word_t diag;
    cdtdr_word_t diag2;
    cdtdr_word_t diag3;
    cdtdr_word_t diag4;
    logic [31:0] peaks;
    logic [1:0]  ev_status;
    logic [1:0]  ev_enable;
    logic        irq;
    cdtdr_word_t rdata;
  } cdtdr_state_t;

endpackage

//--- dv/tb_cable_diag_tdr_regs.sv
// Self-checking bench for the cable diagnostic register bank
`timescale 1ns/1ps
`include "cdtdr_map.svh"

module tb_cable_diag_tdr_regs;
  import cdtdr_pkg::*;

  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  cdtdr_word_t reg_addr = 16'h0000;
  cdtdr_word_t reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  cdtdr_word_t reg_rdata;
  logic        live_check_done = 1'b0;
  logic [7:0]  live_check_sum_in = 8'h00;
  logic        tdr_result_valid = 1'b0;
  logic [31:0] transmit_pair_peaks = 32'h0000_0000;
  logic        gain_retrain_disable;
  logic        live_check_launch;
  logic        cross_mode_disable;
  logic        transmit_pair_bypass;
  logic        rx_pair_bypass;
  logic [2:0]  avg_cycles_code;
  logic [3:0]  pulse_control;
  logic [7:0]  listen_duration;
  logic [4:0]  short_cable_threshold;
  logic        irq;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;

  always #50 sys_clk = ~sys_clk;

  cdtdr_regs dut_u (
    .sys_clk               (sys_clk),
    .resetn                (resetn),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .live_check_done       (live_check_done),
    .live_check_sum_in     (live_check_sum_in),
    .tdr_result_valid      (tdr_result_valid),
    .transmit_pair_peaks   (transmit_pair_peaks),
    .gain_retrain_disable  (gain_retrain_disable),
    .live_check_launch     (live_check_launch),
    .cross_mode_disable    (cross_mode_disable),
    .transmit_pair_bypass  (transmit_pair_bypass),
    .rx_pair_bypass        (rx_pair_bypass),
    .avg_cycles_code       (avg_cycles_code),
    .pulse_control         (pulse_control),
    .listen_duration       (listen_duration),
    .short_cable_threshold (short_cable_threshold),
    .irq                   (irq)
  );

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Both tasks leave the bench 1 ns after the taking edge
  task automatic wr(input cdtdr_word_t a, input cdtdr_word_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input cdtdr_word_t a, input cdtdr_word_t exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {16'h0000, reg_rdata}, {16'h0000, exp});
  endtask

  // One-cycle engine pulse on done or peaks
  task automatic engine(input logic done, input logic [7:0] sum, input logic pk, input logic [31:0] p);
    live_check_done     <= done;
    live_check_sum_in   <= sum;
    tdr_result_valid    <= pk;
    transmit_pair_peaks <= p;
    @(posedge sys_clk);
    live_check_done  <= 1'b0;
    tdr_result_valid <= 1'b0;
    #1;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end

  cdtdr_word_t addrs [11] = '{`CDT_OFF_DSP5, `CDT_OFF_LIVE, `CDT_OFF_DIAG, `CDT_OFF_DIAG2, `CDT_OFF_DIAG3,
    `CDT_OFF_DIAG4, `CDT_OFF_PEAK1, `CDT_OFF_PEAK2, `CDT_OFF_EV_STATUS, `CDT_OFF_EV_ENABLE, 16'h0200};
  cdtdr_word_t rstv [11] = '{16'h0001, 16'h0001, 16'h0e52, 16'hc85c, 16'hff1e, 16'h189b, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};

  initial begin
    @(posedge sys_clk);
    #1;
    chk("reset outputs", {gain_retrain_disable, live_check_launch, cross_mode_disable, transmit_pair_bypass,
        rx_pair_bypass, avg_cycles_code, pulse_control, listen_duration, short_cable_threshold, irq},
        {5'b00000, 3'b110, 4'b1100, 8'hff, 5'h18, 1'b0});
    @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset table, unmapped address last
    for (int i = 0; i < 11; i++) begin
      rd(addrs[i], rstv[i]);
    end
    wr(`CDT_OFF_DSP5, 16'h0801);
    chk("gain off", gain_retrain_disable, 1'b1);
    rd(`CDT_OFF_DSP5, 16'h0801);
    wr(`CDT_OFF_DSP5, 16'h0001);
    chk("gain on", gain_retrain_disable, 1'b0);
    // Averaging codes 0 to 5, bit 15 written but held at zero
    for (int c = 0; c < 6; c++) begin
      wr(`CDT_OFF_DIAG, 16'hd83c | 16'(c << 8));
      chk("diag out", {cross_mode_disable, transmit_pair_bypass, rx_pair_bypass, avg_cycles_code},
          {3'b101, c[2:0]});
      rd(`CDT_OFF_DIAG, 16'h583c | 16'(c << 8));
    end
    // Reserved code refused, neighbours still taken
    wr(`CDT_OFF_DIAG, 16'h2f3c);
    chk("diag rsvd", {cross_mode_disable, transmit_pair_bypass, rx_pair_bypass, avg_cycles_code},
        {3'b010, 3'b101});
    rd(`CDT_OFF_DIAG, 16'h2d3c);
    wr(`CDT_OFF_DIAG2, 16'h1235);
    chk("pulse", pulse_control, 4'h5);
    wr(`CDT_OFF_DIAG3, 16'h5a00);
    chk("listen", listen_duration, 8'h5a);
    wr(`CDT_OFF_DIAG4, 16'hf3c4);
    chk("short", short_cable_threshold, 5'h13);
    rd(`CDT_OFF_DIAG2, 16'h1235);
    rd(`CDT_OFF_DIAG3, 16'h5a00);
    rd(`CDT_OFF_DIAG4, 16'hf3c4);
    // Live check with read-only bits written as ones
    wr(`CDT_OFF_EV_ENABLE, 16'h0001);
    wr(`CDT_OFF_LIVE, 16'hfff5);
    chk("launch", live_check_launch, 1'b1);
    rd(`CDT_OFF_LIVE, 16'h1005);
    chk("launch end", live_check_launch, 1'b0);
    wr(`CDT_OFF_LIVE, 16'h8005);
    chk("relaunch", live_check_launch, 1'b0);
    engine(1'b1, 8'ha7, 1'b0, 32'h0);
    chk("irq done", irq, 1'b1);
    rd(`CDT_OFF_LIVE, 16'h0a75);
    rd(`CDT_OFF_EV_STATUS, 16'h0001);
    wr(`CDT_OFF_EV_CLEAR, 16'h0001);
    chk("irq clr", irq, 1'b0);
    engine(1'b1, 8'h33, 1'b0, 32'h0);
    rd(`CDT_OFF_LIVE, 16'h0a75);
    rd(`CDT_OFF_EV_STATUS, 16'h0000);
    wr(`CDT_OFF_LIVE, 16'h0006);
    chk("no launch", live_check_launch, 1'b0);
    rd(`CDT_OFF_LIVE, 16'h0a76);
    // Peaks arrive with their event masked
    engine(1'b0, 8'h00, 1'b1, 32'h4433_2211);
    chk("irq masked", irq, 1'b0);
    wr(`CDT_OFF_PEAK1, 16'hffff);
    wr(`CDT_OFF_EV_STATUS, 16'h0000);
    rd(`CDT_OFF_PEAK1, 16'h2211);
    rd(`CDT_OFF_PEAK2, 16'h4433);
    rd(`CDT_OFF_EV_STATUS, 16'h0002);
    wr(`CDT_OFF_EV_ENABLE, 16'h0003);
    chk("irq unmask", irq, 1'b1);
    wr(`CDT_OFF_EV_CLEAR, 16'h0002);
    chk("irq clr2", irq, 1'b0);
    rd(`CDT_OFF_EV_CLEAR, 16'h0000);
    // Enabled peak event, raw index read straight after
    engine(1'b0, 8'h00, 1'b1, 32'h8877_6655);
    chk("irq peaks", irq, 1'b1);
    rd(`CDT_OFF_PEAK1, 16'h6655);
    rd(`CDT_OFF_PEAK2, 16'h8877);
    // Clear and new peaks in one cycle: set wins
    reg_addr         <= `CDT_OFF_EV_CLEAR;
    reg_wdata        <= 16'h0002;
    reg_wr           <= 1'b1;
    tdr_result_valid <= 1'b1;
    @(posedge sys_clk);
    reg_wr           <= 1'b0;
    tdr_result_valid <= 1'b0;
    #1;
    chk("set wins", irq, 1'b1);
    rd(`CDT_OFF_EV_STATUS, 16'h0002);
    conclude();
  end
endmodule
